// file: cssc_pkg.sv
package cssc_pkg;
   // byte addresses of the register map
   localparam logic [15:0] CSSC_ADDR_CTRL1   = 16'h3038;
   localparam logic [15:0] CSSC_ADDR_CTRL2   = 16'h3039;
   localparam logic [15:0] CSSC_ADDR_TRIM    = 16'h303a;
   localparam logic [15:0] CSSC_ADDR_CTRL4   = 16'h303b;
   localparam logic [15:0] CSSC_ADDR_STATUS  = 16'h303c;
   localparam logic [15:0] CSSC_ADDR_OSC     = 16'h303e;
   localparam int          CSSC_INDEX_BASE   = 16'h3038;
   // reset values
   localparam logic [7:0]  CSSC_RST_CTRL1    = 8'h04;
   localparam logic [7:0]  CSSC_RST_CTRL2    = 8'h20;
   localparam logic [7:0]  CSSC_RST_TRIM     = 8'h00;
   localparam logic [7:0]  CSSC_RST_CTRL4    = 8'h00;
   localparam logic [7:0]  CSSC_RST_STATUS   = 8'h10;
   localparam logic [7:0]  CSSC_RST_OSC      = 8'h00;
   // field positions
   localparam int          CSSC_SRC_HI       = 7;
   localparam int          CSSC_SRC_LO       = 6;
   localparam int          CSSC_LOOP_REF_DIVIDER_HI      = 5;
   localparam int          CSSC_LOOP_REF_DIVIDER_LO      = 3;
   localparam int          CSSC_REFSEL_BIT   = 2;
   localparam int          CSSC_OUTEN_BIT    = 1;
   localparam int          CSSC_STOPKEEP_BIT = 0;
   localparam int          CSSC_BUS_DIVIDER_HI      = 7;
   localparam int          CSSC_BUS_DIVIDER_LO      = 5;
   localparam int          CSSC_RANGE_BIT    = 5;
   // writable masks; reserved bits of control two and four read zero
   localparam logic [7:0]  CSSC_MASK_CTRL2   = 8'hf0;
   localparam logic [7:0]  CSSC_MASK_CTRL4   = 8'ha1;
   localparam logic [3:0]  CSSC_RANGE_SHIFT  = 4'h5;
   localparam logic [2:0]  CSSC_LOOP_REF_DIVIDER_MAXCODE = 3'h4;

   typedef enum logic [1:0] {
      CSSC_SRC_LOOP     = 2'h0,
      CSSC_SRC_INT_REF  = 2'h1,
      CSSC_SRC_EXT_REF  = 2'h2,
      CSSC_SRC_RESERVED = 2'h3
   } cssc_src_e;
endpackage : cssc_pkg

// file: cssc_ctrl.sv
// Chosen here: register access over APB.
`timescale 1ns/10ps
module cssc_ctrl
   import cssc_pkg::*;
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // clock sources, already on pclk as one-cycle enables
   input  wire logic        loop_clk_en,
   input  wire logic        int_ref_clk_en,
   input  wire logic        ext_ref_clk_en,
   // system state and status bits from outside
   input  wire logic        stop_mode,
   input  wire logic [7:0]  status_in,
   // clock control outputs
   output logic             bus_clk_en,
   output logic             loop_ref_clk_en,
   output logic             int_ref_clock_out,
   output logic             int_ref_running,
   output logic [1:0]       bus_source_sel,
   output logic [2:0]       bus_divider,
   output logic             loop_ref_sel,
   output logic             loop_engaged_internal_mode,
   output logic             loop_bypassed_internal_mode,
   output logic             loop_bypassed_internal_lowpower_mode
);

   logic [7:0]  clock_control_one;
   logic [7:0]  clock_control_two;
   logic [7:0]  reference_trim;
   logic [7:0]  clock_control_four;
   logic [7:0]  clock_status;
   logic [7:0]  oscillator_control;
   logic [7:0]  status_meta;
   logic        stop_meta;
   logic        stop_sync;
   logic        pre_stop_int_mode;
   logic        src_en;
   logic        ref_src_en;
   logic [6:0]  bus_cnt;
   logic [8:0]  ref_cnt;
   logic [2:0]  ref_code;
   logic [3:0]  ref_exp;
   logic [7:0]  rd_byte;
   logic        wr_go;
   logic [7:0]  wbyte;
   logic        int_driven;
   logic        addr_hit;

   function automatic logic [7:0] lane_byte(input logic [31:0] d, input logic [1:0] a);
      lane_byte = d[8*a +: 8];
   endfunction : lane_byte

   // all-ones terminal count (2**code - 1) for a power-of-two divider
   function automatic logic [8:0] pow2_mask(input logic [3:0] code);
      pow2_mask = 9'(({9'h000, 1'b1} << code) - 10'h001);
   endfunction : pow2_mask

   function automatic logic is_mapped(input logic [15:0] a);
      is_mapped = (a == CSSC_ADDR_CTRL1) || (a == CSSC_ADDR_CTRL2) ||
                  (a == CSSC_ADDR_TRIM)  || (a == CSSC_ADDR_CTRL4) ||
                  (a == CSSC_ADDR_STATUS) || (a == CSSC_ADDR_OSC);
   endfunction : is_mapped

   assign pready   = 1'b1;
   assign addr_hit = is_mapped(paddr);
   assign wr_go    = psel && penable && pwrite && addr_hit && pstrb[paddr[1:0]];
   assign wbyte    = lane_byte(pwdata, paddr[1:0]);
   assign pslverr  = psel && penable && (!addr_hit ||
                     (pwrite && paddr == CSSC_ADDR_STATUS));

   // status and stop arrive from other clock domains
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_meta  <= CSSC_RST_STATUS;
         clock_status <= CSSC_RST_STATUS;
         stop_meta    <= 1'b0;
         stop_sync    <= 1'b0;
      end else begin
         status_meta  <= status_in;
         clock_status <= status_meta;
         stop_meta    <= stop_mode;
         stop_sync    <= stop_meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_control_one <= CSSC_RST_CTRL1;
      end else if (wr_go && paddr == CSSC_ADDR_CTRL1) begin
         clock_control_one[CSSC_LOOP_REF_DIVIDER_HI:0] <= wbyte[CSSC_LOOP_REF_DIVIDER_HI:0];
         // reserved source code leaves the bus clock where it was
         if (wbyte[CSSC_SRC_HI:CSSC_SRC_LO] != CSSC_SRC_RESERVED) begin
            clock_control_one[CSSC_SRC_HI:CSSC_SRC_LO] <= wbyte[CSSC_SRC_HI:CSSC_SRC_LO];
         end
      end
   end

   // trim is undefined at reset; zero is loaded so simulation stays clean
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_control_two  <= CSSC_RST_CTRL2;
         reference_trim     <= CSSC_RST_TRIM;
         clock_control_four <= CSSC_RST_CTRL4;
         oscillator_control <= CSSC_RST_OSC;
      end else if (wr_go) begin
         case (paddr)
            CSSC_ADDR_CTRL2: clock_control_two  <= wbyte & CSSC_MASK_CTRL2;
            CSSC_ADDR_TRIM:  reference_trim     <= wbyte;
            CSSC_ADDR_CTRL4: clock_control_four <= wbyte & CSSC_MASK_CTRL4;
            CSSC_ADDR_OSC:   oscillator_control <= wbyte;
            default: ;
         endcase
      end
   end

   always_comb begin
      case (paddr)
         CSSC_ADDR_CTRL1:  rd_byte = clock_control_one;
         CSSC_ADDR_CTRL2:  rd_byte = clock_control_two;
         CSSC_ADDR_TRIM:   rd_byte = reference_trim;
         CSSC_ADDR_CTRL4:  rd_byte = clock_control_four;
         CSSC_ADDR_STATUS: rd_byte = clock_status;
         CSSC_ADDR_OSC:    rd_byte = oscillator_control;
         default:          rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h00_0000, rd_byte} << {paddr[1:0], 3'h0};
      end
   end

   assign bus_source_sel = clock_control_one[CSSC_SRC_HI:CSSC_SRC_LO];
   assign bus_divider    = clock_control_two[CSSC_BUS_DIVIDER_HI:CSSC_BUS_DIVIDER_LO];
   assign loop_ref_sel   = clock_control_one[CSSC_REFSEL_BIT];

   always_comb begin
      case (cssc_src_e'(bus_source_sel))
         CSSC_SRC_LOOP:    src_en = loop_clk_en;
         CSSC_SRC_INT_REF: src_en = int_ref_clk_en;
         CSSC_SRC_EXT_REF: src_en = ext_ref_clk_en;
         default:          src_en = 1'b0;
      endcase
   end

   assign ref_src_en = loop_ref_sel ? int_ref_clk_en : ext_ref_clk_en;

   // bus divider: count selected-source ticks, pulse every 2**code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_cnt    <= 7'h00;
         bus_clk_en <= 1'b0;
      end else begin
         bus_clk_en <= 1'b0;
         if (src_en) begin
            if (bus_cnt >= 7'(pow2_mask({1'b0, bus_divider}))) begin
               bus_cnt    <= 7'h00;
               bus_clk_en <= 1'b1;
            end else begin
               bus_cnt <= bus_cnt + 7'h01;
            end
         end
      end
   end

   // codes above 100 clamp to the largest ratio of the range
   always_comb begin
      ref_code = clock_control_one[CSSC_LOOP_REF_DIVIDER_HI:CSSC_LOOP_REF_DIVIDER_LO];
      if (ref_code > CSSC_LOOP_REF_DIVIDER_MAXCODE) begin
         ref_code = CSSC_LOOP_REF_DIVIDER_MAXCODE;
      end
      ref_exp = {1'b0, ref_code} +
                (oscillator_control[CSSC_RANGE_BIT] ? CSSC_RANGE_SHIFT : 4'h0);
   end

   // loop reference divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt         <= 9'h000;
         loop_ref_clk_en <= 1'b0;
      end else begin
         loop_ref_clk_en <= 1'b0;
         if (ref_src_en) begin
            if (ref_cnt >= pow2_mask(ref_exp)) begin
               ref_cnt         <= 9'h000;
               loop_ref_clk_en <= 1'b1;
            end else begin
               ref_cnt <= ref_cnt + 9'h001;
            end
         end
      end
   end

   // internal-reference-driven modes; low power bit is bit 4 of control two
   assign loop_engaged_internal_mode  = (bus_source_sel == CSSC_SRC_LOOP) && loop_ref_sel;
   assign loop_bypassed_internal_mode = (bus_source_sel == CSSC_SRC_INT_REF) &&
                                        !clock_control_two[4];
   assign loop_bypassed_internal_lowpower_mode = (bus_source_sel == CSSC_SRC_INT_REF) &&
                                                 clock_control_two[4];
   assign int_driven = loop_engaged_internal_mode || loop_bypassed_internal_mode ||
                       loop_bypassed_internal_lowpower_mode;

   // mode is frozen at stop entry so a later write changes the decision only through the stop-keep and output enable bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_stop_int_mode <= 1'b0;
      end else if (!stop_sync) begin
         pre_stop_int_mode <= int_driven;
      end
   end

   always_comb begin
      if (!stop_sync) begin
         int_ref_running = 1'b1;
      end else if (!clock_control_one[CSSC_STOPKEEP_BIT]) begin
         int_ref_running = 1'b0;
      end else begin
         int_ref_running = clock_control_one[CSSC_OUTEN_BIT] || pre_stop_int_mode;
      end
   end

   assign int_ref_clock_out = clock_control_one[CSSC_OUTEN_BIT] && int_ref_running &&
                              int_ref_clk_en;
endmodule : cssc_ctrl

// file: cssc_ctrl_monitor.sv
`timescale 1ns/10ps
module cssc_ctrl_monitor
   import cssc_pkg::*;
(
   // apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pslverr,
   // sources and state
   input wire logic        loop_clk_en,
   input wire logic        int_ref_clk_en,
   input wire logic        ext_ref_clk_en,
   input wire logic        stop_mode,
   // clock control
   input wire logic        bus_clk_en,
   input wire logic        int_ref_clock_out,
   input wire logic        int_ref_running,
   input wire logic [1:0]  bus_source_sel,
   input wire logic [2:0]  bus_divider
);
   wire wa = psel & penable & pwrite;
   wire w1 = wa & (paddr == CSSC_ADDR_CTRL1) & pstrb[0];
   wire tk = (bus_source_sel == 2'h0) ? loop_clk_en :
             (bus_source_sel == 2'h1) ? int_ref_clk_en : ext_ref_clk_en;
   // shadow of the output enable and stop-keep bits, taken from bus writes
   logic        oen_sh;
   logic        keep_sh;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oen_sh  <= CSSC_RST_CTRL1[CSSC_OUTEN_BIT];
         keep_sh <= CSSC_RST_CTRL1[CSSC_STOPKEEP_BIT];
      end else if (w1) begin
         oen_sh  <= pwdata[CSSC_OUTEN_BIT];
         keep_sh <= pwdata[CSSC_STOPKEEP_BIT];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_SRC: assert property (w1 && pwdata[7:6] != 2'h3 |=>
      bus_source_sel == $past(pwdata[7:6])) else $error("source not taken");
   AST_RSVD: assert property (w1 && pwdata[7:6] == 2'h3 |=>
      $stable(bus_source_sel)) else $error("reserved source taken");
   AST_BUS_DIVIDER: assert property (wa && paddr == CSSC_ADDR_CTRL2 && pstrb[1] |=>
      bus_divider == $past(pwdata[15:13])) else $error("divider not taken");
   AST_STERR: assert property (wa && paddr == CSSC_ADDR_STATUS |-> pslverr)
      else $error("status write accepted");
   AST_MAPOK: assert property (psel && penable && paddr == CSSC_ADDR_CTRL1 |-> !pslverr)
      else $error("mapped access refused");
   AST_REFOUT: assert property (int_ref_clock_out == (oen_sh && int_ref_running && int_ref_clk_en))
      else $error("ref output does not follow enable");
   AST_RUN: assert property (!stop_mode [*4] |-> int_ref_running)
      else $error("ref stopped outside stop");
   AST_STOPOFF: assert property (stop_mode [*3] ##1 (stop_mode && !keep_sh) |-> !int_ref_running)
      else $error("ref running in stop without keep");
   AST_BUSCLK: assert property (bus_clk_en |-> $past(tk))
      else $error("bus tick without source tick");
   cover property (w1);
   cover property (bus_clk_en && bus_divider == 3'h7);
   cover property (stop_mode && int_ref_running);
   cover property (w1 && pwdata[7:6] == 2'h3);
endmodule : cssc_ctrl_monitor

// file: cssc_ctrl_test.sv
`timescale 1ns/10ps
module cssc_ctrl_test;
   import cssc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, stop_mode;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [7:0]  status_in, r, d;
   logic [2:0]  ticks, tmode;
   logic [1:0]  bus_source_sel, es;
   logic [2:0]  bus_divider;
   logic        pready, pslverr, bus_clk_en, loop_ref_clk_en, int_ref_clock_out, e;
   logic        int_ref_running, loop_ref_sel, lei, lbi, lbl;
   int          fail_count, n_checks, k;
   logic [15:0] ad[5] = '{CSSC_ADDR_CTRL1, CSSC_ADDR_CTRL2, CSSC_ADDR_CTRL4,
                          CSSC_ADDR_STATUS, CSSC_ADDR_OSC};
   logic [7:0]  rv[5] = '{8'h04, 8'h20, 8'h00, 8'h10, 8'h00};
   logic [15:0] wad[4] = '{CSSC_ADDR_CTRL2, CSSC_ADDR_TRIM, CSSC_ADDR_CTRL4, CSSC_ADDR_OSC};
   logic [7:0]  mk[4] = '{8'hf0, 8'hff, 8'ha1, 8'hff};
   logic [7:0]  sv[5] = '{8'h04, 8'h07, 8'h05, 8'h41, 8'h81};
   logic        se[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   cssc_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .loop_clk_en(ticks[0]), .int_ref_clk_en(ticks[1]),
      .ext_ref_clk_en(ticks[2]), .stop_mode, .status_in, .bus_clk_en, .loop_ref_clk_en,
      .int_ref_clock_out, .int_ref_running, .bus_source_sel, .bus_divider, .loop_ref_sel,
      .loop_engaged_internal_mode(lei), .loop_bypassed_internal_mode(lbi),
      .loop_bypassed_internal_lowpower_mode(lbl));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // random source ticks, steady ticks while counting
   always @(posedge pclk) ticks <= (tmode != 3'h0) ? tmode : 3'($urandom);
   task automatic final_report;
      if (fail_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   // pulse counts may land one off by phase
   task automatic near(input string n, input int x, input int g);
      n_checks++;
      if (g > x + 1 || g < x - 1) begin
         fail_count++;
         $display("[FAIL] %s expected %0d seen %0d", n, x, g);
      end
   endtask : near
   task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] v);
      int i;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, v} << (8 * a[1:0]);
      pstrb   <= 4'h1 << a[1:0];
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
         fail_count++;
         final_report();
      end
      r = 8'(prdata >> (8 * a[1:0]));
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cnt(input int n, input bit lp);
      k = 0;
      repeat (8) @(posedge pclk);
      repeat (n) begin
         @(negedge pclk);
         k += int'((lp ? loop_ref_clk_en : bus_clk_en) === 1'b1);
      end
   endtask : cnt
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, stop_mode, tmode} = '0;
      status_in = 8'h10;
      void'($urandom(32'h3c3f));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ad[i], 8'h00);
         chk("reset value", rv[i], r);
      end
      es = 2'h0;
      for (int s = 0; s < 4; s++) begin
         d = 8'($urandom);
         d[7:6] = 2'(s);
         apb(1'b1, CSSC_ADDR_CTRL1, d);
         if (s != 3) es = 2'(s);
         apb(1'b0, CSSC_ADDR_CTRL1, 8'h00);
         chk("ctrl1", {es, d[5:0]}, r);
         chk("source", es, bus_source_sel);
         chk("ref select", d[2], loop_ref_sel);
         chk("engaged mode", es == 2'h0 && d[2], lei);
         chk("bypass mode", es == 2'h1, lbi);
      end
      for (int i = 0; i < 12; i++) begin
         d = 8'($urandom);
         apb(1'b1, wad[i % 4], d);
         apb(1'b0, wad[i % 4], 8'h00);
         chk("readback", d & mk[i % 4], r);
      end
      status_in <= 8'($urandom);
      apb(1'b1, CSSC_ADDR_STATUS, ~status_in);
      chk("status write err", 1'b1, e);
      apb(1'b0, CSSC_ADDR_STATUS, 8'h00);
      chk("status", status_in, r);
      apb(1'b1, 16'h303d, 8'hff);
      chk("unmapped err", 1'b1, e);
      apb(1'b0, 16'h303d, 8'h00);
      chk("unmapped data", 8'h00, r);
      apb(1'b1, CSSC_ADDR_CTRL2, 8'h10);
      apb(1'b1, CSSC_ADDR_CTRL1, 8'h40);
      @(negedge pclk);
      chk("lowpower bypass mode", 1'b1, lbl);
      chk("bypass mode low power", 1'b0, lbi);
      tmode <= 3'h7;
      apb(1'b1, CSSC_ADDR_CTRL1, 8'h04);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, CSSC_ADDR_CTRL2, {3'(c), 5'h0});
         cnt(256, 1'b0);
         near("bus ticks", 256 >> c, k);
      end
      for (int g = 0; g < 2; g++) begin
         for (int c = 0; c < 6; c++) begin
            apb(1'b1, CSSC_ADDR_OSC, 8'(g << 5));
            apb(1'b1, CSSC_ADDR_CTRL1, {2'h0, 3'(c), 3'h4});
            cnt(512, 1'b1);
            near("loop ref ticks", 512 >> ((c > 4 ? 4 : c) + 5 * g), k);
         end
      end
      // external reference silent: its selections must give no ticks
      tmode <= 3'h3;
      apb(1'b1, CSSC_ADDR_CTRL1, 8'h80);
      cnt(64, 1'b0);
      chk("bus ticks from silent source", 0, k);
      cnt(64, 1'b1);
      chk("loop ref ticks from silent source", 0, k);
      tmode <= 3'h7;
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, CSSC_ADDR_CTRL1, sv[i]);
         stop_mode <= 1'b1;
         repeat (5) @(negedge pclk);
         chk("ref running", se[i], int_ref_running);
         chk("ref output", sv[i][1] & se[i], int_ref_clock_out);
         @(posedge pclk);
         stop_mode <= 1'b0;
         repeat (5) @(posedge pclk);
      end
      // reset again in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CSSC_ADDR_CTRL1, 8'h00);
      chk("ctrl1 after reset", 8'h04, r);
      apb(1'b0, CSSC_ADDR_CTRL2, 8'h00);
      chk("ctrl2 after reset", 8'h20, r);
      final_report();
   end
endmodule : cssc_ctrl_test
bind cssc_ctrl cssc_ctrl_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .pslverr, .loop_clk_en, .int_ref_clk_en, .ext_ref_clk_en, .stop_mode,
   .bus_clk_en, .int_ref_clock_out, .int_ref_running, .bus_source_sel, .bus_divider);
